// ---- verilog/ata_read_and_idle_command_engine.v ----
// card-side task file and executor for idle, parameter and read commands
// assumes host strobes are synchronous one-cycle pulses, reads spaced >= 2
// What this block does
// - idle immediate: busy, idle mode, unbusy, interrupt
// - parameter command loads sectors and heads only
// - nop always ends with command aborted
// - read buffer returns buffer like pio read
// - dma read moves 1..256 sectors, zero=256
// - dma read starts at addressed sector
// - dma read holds busy while buffer fills
// - dmarq while data ready, 512 bytes/sector
// - dma interrupts only at end or error
// - byte mode enabled aborts dma read
// - multiple read: blocks, no per-sector interrupt
// - full blocks first, then remainder block
// - multiple read aborted without block size set
// - media errors posted as the failing sector loads; an uncorrectable one ends a dma read there
// - interrupt when drq set at each block
// - multiple read 1..256 sectors, zero=256
// - error freezes failing address, data kept
// - only correctable errors continue past block
// - pio sector: busy, load, drq, interrupt
`include "ata_cmd_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ata_read_and_idle_command_engine #(
    parameter FIFO_DEPTH = `FIFO_WORDS,
    parameter FIFO_AW    = 4
) (
    // clock and reset
    input  wire        clock,
    input  wire        reset,
    // task-file access
    input  wire [2:0]  tf_addr,
    input  wire [15:0] tf_wdata,
    input  wire        tf_wr,
    input  wire        tf_rd,
    output reg  [15:0] tf_rdata,
    // host interrupt
    output reg         intrq,
    // multi-word dma
    output reg         dmarq,
    input  wire        dmack_n,
    input  wire        iord_n,
    output reg  [15:0] dma_data,
    // settings from other commands, power state
    input  wire        byte_mode_en,
    input  wire [8:0]  multi_block_size,
    output reg         idle_mode,
    // media back end
    output reg         media_req,
    output wire        media_lba_mode,
    output wire [27:0] media_addr,
    input  wire [15:0] media_data,
    input  wire        media_valid,
    output wire        media_ready,
    input  wire        media_corr_err,
    input  wire        media_unc_err
);
    localparam S_IDLE = 3'h0;
    localparam S_PWR  = 3'h1;
    localparam S_REQ  = 3'h2;
    localparam S_LOAD = 3'h3;
    localparam S_XFER = 3'h4;
    localparam S_DMA  = 3'h5;
    localparam S_NEXT = 3'h6;

    localparam K_BUF  = 2'h0;
    localparam K_DMA  = 2'h1;
    localparam K_MULT = 2'h2;

    reg [7:0]  feature_byte_ff;
    reg [7:0]  sector_count_byte_ff;
    reg [7:0]  sector_number_byte_ff;
    reg [7:0]  cylinder_low_byte_ff;
    reg [7:0]  cylinder_high_byte_ff;
    reg [7:0]  drive_head_select_ff;
    reg [7:0]  spt_ff;
    reg [3:0]  max_head_ff;
    reg [2:0]  state_ff;
    reg [1:0]  kind_ff;
    reg        bsy_ff;
    reg        drq_ff;
    reg        err_ff;
    reg        abrt_ff;
    reg        unc_ff;
    reg        corr_ff;
    reg        stop_ff;
    reg        first_ff;
    reg        iord_d_ff;
    reg [8:0]  remain_ff;
    reg [8:0]  blk_left_ff;
    reg [8:0]  wr_ptr_ff;
    reg [8:0]  rd_ptr_ff;

    wire        fifo_valid;
    wire [15:0] fifo_data;
    wire [15:0] buf_q;
    wire        load_pop;
    wire        cmd_wr;
    wire        data_rd;
    wire        dma_take;
    wire        last_wr;
    wire        last_rd;
    wire [8:0]  req_count;
    wire [7:0]  status_byte;
    wire [7:0]  error_byte;
    wire [15:0] cyl_word;
    wire [27:0] lba_word;

    // sectors in the next block: whole block or what is left
    function [8:0] block_len;
        input [8:0] remain;
        input [8:0] bsz;
        begin
            block_len = (remain < bsz) ? remain : bsz;
        end
    endfunction

    assign cmd_wr    = tf_wr & (tf_addr == `TF_COMMAND) & ~bsy_ff;
    assign data_rd   = tf_rd & (tf_addr == `TF_DATA) & (state_ff == S_XFER);
    // host takes a word on the falling edge of its read strobe under ack
    assign dma_take  = (state_ff == S_DMA) & iord_d_ff & ~iord_n & ~dmack_n;
    assign load_pop  = (state_ff == S_LOAD) & fifo_valid;
    assign last_wr   = load_pop & (wr_ptr_ff == `SECTOR_WORDS - 9'h1);
    assign last_rd   = rd_ptr_ff == `SECTOR_WORDS - 9'h1;
    assign req_count = (sector_count_byte_ff == 8'h00) ? `FULL_COUNT
                       : {1'b0, sector_count_byte_ff};
    assign cyl_word  = {cylinder_high_byte_ff, cylinder_low_byte_ff};
    assign lba_word  = {drive_head_select_ff[`DH_HEAD_MSB:0], cyl_word,
                        sector_number_byte_ff};
    assign media_addr     = lba_word;
    assign media_lba_mode = drive_head_select_ff[`DH_LBA];

    assign status_byte = {bsy_ff, ~bsy_ff, 1'b0, 1'b1, drq_ff, corr_ff,
                          1'b0, err_ff};
    assign error_byte  = {1'b0, unc_ff, 3'h0, abrt_ff, 2'h0};

    // media words queue here; the back end stalls only while the fifo is full
    sync_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (media_valid),
        .in_ready  (media_ready),
        .in_data   (media_data),
        .out_valid (fifo_valid),
        .out_ready (state_ff == S_LOAD),
        .out_data  (fifo_data)
    );

    sector_buffer #(
        .WIDTH (16),
        .AW    (8)
    ) u_buf (
        .clock   (clock),
        .wr_en   (load_pop),
        .wr_addr (wr_ptr_ff[7:0]),
        .wr_data (fifo_data),
        .rd_addr (rd_ptr_ff[7:0]),
        .rd_data (buf_q)
    );

    // register reads; a status read acknowledges the interrupt
    always @(posedge clock) begin
        if (reset) begin
            tf_rdata <= 16'h0000;
        end else if (tf_rd) begin
            case (tf_addr)
                `TF_DATA:          tf_rdata <= data_rd ? buf_q : 16'h0000;
                `TF_FEATURE:       tf_rdata <= {8'h00, error_byte};
                `TF_SECTOR_COUNT:  tf_rdata <= {8'h00, sector_count_byte_ff};
                `TF_SECTOR_NUMBER: tf_rdata <= {8'h00, sector_number_byte_ff};
                `TF_CYL_LOW:       tf_rdata <= {8'h00, cylinder_low_byte_ff};
                `TF_CYL_HIGH:      tf_rdata <= {8'h00, cylinder_high_byte_ff};
                `TF_DRIVE_HEAD:    tf_rdata <= {8'h00, drive_head_select_ff};
                default:           tf_rdata <= {8'h00, status_byte};
            endcase
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            feature_byte_ff       <= `TF_RESET;
            sector_count_byte_ff  <= `TF_RESET;
            sector_number_byte_ff <= `TF_RESET;
            cylinder_low_byte_ff  <= `TF_RESET;
            cylinder_high_byte_ff <= `TF_RESET;
            drive_head_select_ff  <= `TF_RESET;
            spt_ff      <= `SPT_RESET;
            max_head_ff <= `MAX_HEAD_RESET;
            state_ff    <= S_IDLE;
            kind_ff     <= K_BUF;
            bsy_ff      <= 1'b0;
            drq_ff      <= 1'b0;
            err_ff      <= 1'b0;
            abrt_ff     <= 1'b0;
            unc_ff      <= 1'b0;
            corr_ff     <= 1'b0;
            stop_ff     <= 1'b0;
            first_ff    <= 1'b0;
            iord_d_ff   <= 1'b1;
            remain_ff   <= 9'h000;
            blk_left_ff <= 9'h000;
            wr_ptr_ff   <= 9'h000;
            rd_ptr_ff   <= 9'h000;
            intrq       <= 1'b0;
            dmarq       <= 1'b0;
            dma_data    <= 16'h0000;
            idle_mode   <= 1'b0;
            media_req   <= 1'b0;
        end else begin
            iord_d_ff <= iord_n;
            media_req <= 1'b0;
            // clear first so that a same-cycle completion still interrupts
            if (tf_rd & (tf_addr == `TF_COMMAND)) begin
                intrq <= 1'b0;
            end
            // task-file writes are refused while busy
            if (tf_wr & ~bsy_ff) begin
                case (tf_addr)
                    `TF_FEATURE:       feature_byte_ff <= tf_wdata[7:0];
                    `TF_SECTOR_COUNT:  sector_count_byte_ff <= tf_wdata[7:0];
                    `TF_SECTOR_NUMBER: sector_number_byte_ff <= tf_wdata[7:0];
                    `TF_CYL_LOW:       cylinder_low_byte_ff <= tf_wdata[7:0];
                    `TF_CYL_HIGH:      cylinder_high_byte_ff <= tf_wdata[7:0];
                    `TF_DRIVE_HEAD:    drive_head_select_ff <= tf_wdata[7:0];
                    default:           ;
                endcase
            end
            case (state_ff)
                S_IDLE: begin
                    if (cmd_wr) begin
                        intrq   <= 1'b0;
                        err_ff  <= 1'b0;
                        abrt_ff <= 1'b0;
                        unc_ff  <= 1'b0;
                        corr_ff <= 1'b0;
                        stop_ff <= 1'b0;
                        drq_ff  <= 1'b0;
                        case (tf_wdata[7:0])
                            `OP_IDLE_IMM_A, `OP_IDLE_IMM_B: begin
                                bsy_ff   <= 1'b1;
                                state_ff <= S_PWR;
                            end
                            `OP_INIT_PARAMS: begin
                                spt_ff      <= sector_count_byte_ff;
                                max_head_ff <= drive_head_select_ff[3:0];
                                intrq       <= 1'b1;
                            end
                            `OP_READ_BUFFER: begin
                                // buffer is already loaded: straight to drq
                                kind_ff     <= K_BUF;
                                idle_mode   <= 1'b0;
                                rd_ptr_ff   <= 9'h000;
                                drq_ff      <= 1'b1;
                                intrq       <= 1'b1;
                                state_ff    <= S_XFER;
                            end
                            `OP_READ_DMA: begin
                                if (byte_mode_en) begin
                                    abrt_ff <= 1'b1;
                                    err_ff  <= 1'b1;
                                    intrq   <= 1'b1;
                                end else begin
                                    kind_ff   <= K_DMA;
                                    idle_mode <= 1'b0;
                                    remain_ff <= req_count;
                                    bsy_ff    <= 1'b1;
                                    state_ff  <= S_REQ;
                                end
                            end
                            `OP_READ_MULTIPLE: begin
                                if (multi_block_size == 9'h000) begin
                                    abrt_ff <= 1'b1;
                                    err_ff  <= 1'b1;
                                    intrq   <= 1'b1;
                                end else begin
                                    kind_ff     <= K_MULT;
                                    idle_mode   <= 1'b0;
                                    remain_ff   <= req_count;
                                    blk_left_ff <= block_len(req_count,
                                                   multi_block_size);
                                    first_ff    <= 1'b1;
                                    bsy_ff      <= 1'b1;
                                    state_ff    <= S_REQ;
                                end
                            end
                            default: begin
                                // nop and every opcode not handled here
                                abrt_ff <= 1'b1;
                                err_ff  <= 1'b1;
                                intrq   <= 1'b1;
                            end
                        endcase
                    end
                end
                S_PWR: begin
                    idle_mode <= 1'b1;
                    bsy_ff    <= 1'b0;
                    intrq     <= 1'b1;
                    state_ff  <= S_IDLE;
                end
                S_REQ: begin
                    media_req <= 1'b1;
                    wr_ptr_ff <= 9'h000;
                    state_ff  <= S_LOAD;
                end
                S_LOAD: begin
                    if (load_pop) begin
                        wr_ptr_ff <= wr_ptr_ff + 9'h001;
                    end
                    if (last_wr) begin
                        rd_ptr_ff <= 9'h000;
                        if (media_unc_err) begin
                            err_ff  <= 1'b1;
                            unc_ff  <= 1'b1;
                            stop_ff <= 1'b1;
                        end
                        if (media_corr_err) begin
                            corr_ff <= 1'b1;
                        end
                        if (kind_ff == K_DMA) begin
                            if (media_unc_err) begin
                                // address stays on the failing sector
                                bsy_ff   <= 1'b0;
                                intrq    <= 1'b1;
                                state_ff <= S_IDLE;
                            end else begin
                                dmarq    <= 1'b1;
                                state_ff <= S_DMA;
                            end
                        end else begin
                            bsy_ff   <= 1'b0;
                            drq_ff   <= 1'b1;
                            if (first_ff) intrq <= 1'b1;
                            first_ff <= 1'b0;
                            state_ff <= S_XFER;
                        end
                    end
                end
                S_XFER: begin
                    if (data_rd) begin
                        rd_ptr_ff <= rd_ptr_ff + 9'h001;
                        if (last_rd) begin
                            drq_ff   <= 1'b0;
                            state_ff <= S_NEXT;
                        end
                    end
                end
                S_DMA: begin
                    if (dma_take) begin
                        dma_data  <= buf_q;
                        rd_ptr_ff <= rd_ptr_ff + 9'h001;
                        if (last_rd) begin
                            dmarq    <= 1'b0;
                            state_ff <= S_NEXT;
                        end
                    end
                end
                S_NEXT: begin
                    if (kind_ff == K_BUF) begin
                        state_ff <= S_IDLE;
                    end else begin
                        if (~stop_ff) begin
                            sector_count_byte_ff <= sector_count_byte_ff
                                                    - 8'h01;
                            if (drive_head_select_ff[`DH_LBA]) begin
                                {drive_head_select_ff[`DH_HEAD_MSB:0],
                                 cylinder_high_byte_ff, cylinder_low_byte_ff,
                                 sector_number_byte_ff} <= lba_word + 28'h1;
                            end else if (sector_number_byte_ff >= spt_ff) begin
                                sector_number_byte_ff <= 8'h01;
                                if (drive_head_select_ff[3:0] >= max_head_ff)
                                begin
                                    drive_head_select_ff[3:0] <= 4'h0;
                                    {cylinder_high_byte_ff,
                                     cylinder_low_byte_ff} <= cyl_word + 16'h1;
                                end else begin
                                    drive_head_select_ff[3:0] <=
                                        drive_head_select_ff[3:0] + 4'h1;
                                end
                            end else begin
                                sector_number_byte_ff <= sector_number_byte_ff
                                                         + 8'h01;
                            end
                        end
                        remain_ff   <= remain_ff - 9'h001;
                        blk_left_ff <= blk_left_ff - 9'h001;
                        if ((remain_ff == 9'h001) ||
                            (stop_ff && (blk_left_ff == 9'h001))) begin
                            bsy_ff   <= 1'b0;
                            if (kind_ff == K_DMA) intrq <= 1'b1;
                            state_ff <= S_IDLE;
                        end else begin
                            bsy_ff <= 1'b1;
                            if (blk_left_ff == 9'h001) begin
                                blk_left_ff <= block_len(remain_ff - 9'h001,
                                               multi_block_size);
                                first_ff    <= 1'b1;
                            end
                            state_ff <= S_REQ;
                        end
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end
endmodule // ata_read_and_idle_command_engine
`default_nettype wire

// ---- verilog/ata_cmd_defines.vh ----
// constants for the ata read and idle command engine
// assumes inclusion by bare name from each design file
`ifndef ATA_CMD_DEFINES_VH
`define ATA_CMD_DEFINES_VH

// task-file offsets
`define TF_DATA           3'h0
`define TF_FEATURE        3'h1
`define TF_SECTOR_COUNT   3'h2
`define TF_SECTOR_NUMBER  3'h3
`define TF_CYL_LOW        3'h4
`define TF_CYL_HIGH       3'h5
`define TF_DRIVE_HEAD     3'h6
`define TF_COMMAND        3'h7

// opcodes
`define OP_IDLE_IMM_A     8'h95
`define OP_IDLE_IMM_B     8'he1
`define OP_INIT_PARAMS    8'h91
`define OP_NOP            8'h00
`define OP_READ_BUFFER    8'he4
`define OP_READ_DMA       8'hc8
`define OP_READ_MULTIPLE  8'hc4

// status bits
`define ST_BSY            7
`define ST_DRDY           6
`define ST_DSC            4
`define ST_DRQ            3
`define ST_CORR           2
`define ST_ERR            0
// error bits
`define ER_UNC            6
`define ER_ABRT           2
// drive/head fields
`define DH_LBA            6
`define DH_HEAD_MSB       3

// sizes and reset values
`define SECTOR_WORDS      9'h100
`define FULL_COUNT        9'h100
`define FIFO_WORDS        16
`define TF_RESET          8'h00
`define SPT_RESET         8'h20
`define MAX_HEAD_RESET    4'hf

`endif

// ---- verilog/sync_fifo.v ----
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module sync_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clock,
    input  wire             reset,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wr_ff;
    reg [AW-1:0]    rd_ff;
    reg [AW:0]      cnt_ff;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            wr_ff  <= {AW{1'b0}};
            rd_ff  <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                         : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                         : rd_ff + 1'b1;
            end
            if (push & ~pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop & ~push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // sync_fifo
`default_nettype wire

// ---- verilog/sector_buffer.v ----
// one-sector word buffer, registered read port
// assumes the reader allows one cycle for the read data to follow
`timescale 1ns/10ps
`default_nettype none
module sector_buffer #(
    parameter WIDTH = 16,
    parameter AW    = 8
) (
    // clock
    input  wire             clock,
    // write port
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    // read port
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem_ff [0:(1<<AW)-1];

    always @(posedge clock) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
        rd_data <= mem_ff[rd_addr];
    end
endmodule // sector_buffer
`default_nettype wire

// ---- verification/ata_engine_monitor.sv ----
// port assertions for the read and idle command engine
// assumes commands are only written while the engine is idle
`timescale 1ns/10ps
`default_nettype none
module ata_engine_monitor (
    input wire logic        clock, reset, tf_wr, intrq, dmarq,
    input wire logic        dmack_n, idle_mode, media_req, byte_mode_en,
    input wire logic [2:0]  tf_addr,
    input wire logic [15:0] tf_wdata,
    input wire logic [8:0]  multi_block_size
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire       cw = tf_wr && tf_addr == 3'h7;
    wire [7:0] op = tf_wdata[7:0];
    property p_nop; cw && op == 8'h00 |=> intrq && !media_req; endproperty
    a_nop: assert property (p_nop) else $error("nop not aborted");
    property p_idle; cw && (op == 8'h95 || op == 8'he1)
        |=> ##1 idle_mode && intrq; endproperty
    a_idle: assert property (p_idle) else $error("idle entry");
    property p_init; cw && op == 8'h91 |=> intrq; endproperty
    a_init: assert property (p_init) else $error("init no irq");
    property p_dma; cw && op == 8'hc8 && !byte_mode_en
        |=> !intrq ##1 media_req; endproperty
    a_dma: assert property (p_dma) else $error("dma no fetch");
    property p_dabt; cw && op == 8'hc8 && byte_mode_en
        |=> intrq && !media_req ##1 !media_req; endproperty
    a_dabt: assert property (p_dabt) else $error("byte mode dma");
    property p_mabt; cw && op == 8'hc4 && multi_block_size == 9'h000
        |=> intrq ##1 !media_req; endproperty
    a_mabt: assert property (p_mabt) else $error("multi abort");
    property p_dint; dmarq |-> !intrq; endproperty
    a_dint: assert property (p_dint) else $error("dma irq early");
    property p_load; media_req |-> !dmarq [*8]; endproperty
    a_load: assert property (p_load) else $error("dmarq early");
    property p_hold; $rose(dmarq) && dmack_n |=> dmarq; endproperty
    a_hold: assert property (p_hold) else $error("dmarq dropped");
    cover property (cw && op == 8'hc8 ##[1:20] media_req);
    cover property ($rose(dmarq));
    cover property (cw && op == 8'hc4 && multi_block_size != 9'h000);
endmodule // ata_engine_monitor
bind ata_read_and_idle_command_engine ata_engine_monitor i_mon (.*);
`default_nettype wire

// ---- verification/media_model.sv ----
// media back end: 256 words a sector, word = {sector byte, index}
// assumes the bench holds unc_on steady across a command
`timescale 1ns/10ps
`default_nettype none
module media_model (
    input wire logic        clock, reset, media_req, media_ready,
    input wire logic        stall, unc_on,
    input wire logic [27:0] media_addr,
    output logic            media_valid, media_corr_err, media_unc_err,
    output logic [15:0]     media_data
);
    logic [8:0] left;
    logic [7:0] idx, sec;
    assign media_valid = left != 9'h000 && !stall;
    // idle bus shows inverted data so a stale word never matches
    assign media_data = media_valid ? {sec, idx} : ~{sec, idx};
    assign media_unc_err = unc_on;
    assign media_corr_err = 1'b0;
    always @(posedge clock) begin
        if (reset) left <= 9'h000;
        else if (media_req) begin
            left <= 9'h100;
            idx <= 8'h00;
            sec <= media_addr[7:0];
        end else if (media_valid && media_ready) begin
            left <= left - 9'h001;
            idx <= idx + 8'h01;
        end
    end
endmodule // media_model
`default_nettype wire

// ---- verification/ata_read_and_idle_command_engine_tb_top.sv ----
// self-checking bench for the read and idle command engine
// assumes media_model.sv and the monitor are compiled first
`timescale 1ns/10ps
`default_nettype none
module ata_read_and_idle_command_engine_tb_top;
    logic clock = 0, reset = 1, tf_wr = 0, tf_rd = 0, dmack_n = 1;
    logic iord_n = 1, byte_mode_en = 0, unc_on = 0, stall = 0;
    logic media_req, media_ready, media_valid, media_corr_err;
    logic media_unc_err, intrq, dmarq, idle_mode, media_lba_mode;
    logic [2:0]  tf_addr = 0;
    logic [15:0] tf_wdata = 0, tf_rdata, dma_data, media_data, r;
    logic [8:0]  multi_block_size = 0;
    logic [27:0] media_addr;
    logic [31:0] rng = 32'h57fe717d;
    logic [7:0]  s;
    int error_cnt = 0, total_checks = 0, ints = 0;
    ata_read_and_idle_command_engine i_dut (.*);
    media_model i_media (.*);
    initial forever #5 clock = ~clock;
    always @(posedge intrq) ints++;
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    always @(negedge clock) stall <= xs() > 32'hc0000000;
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(negedge clock); tf_addr = a; tf_wdata = {8'h00, d}; tf_wr = 1;
        @(negedge clock); tf_wr = 0;
    endtask
    task automatic rd(logic [2:0] a);
        @(negedge clock); tf_addr = a; tf_rd = 1;
        @(negedge clock); tf_rd = 0;
        @(negedge clock); r = tf_rdata;
    endtask
    task automatic wint();
        for (int i = 0; i < 900 && intrq !== 1'b1; i++) @(negedge clock);
    endtask
    task automatic pio(logic [7:0] sn);
        for (int i = 0; i < 900 && (i == 0 || r[7:0] !== 8'h58); i++) rd(7);
        chk("drq", 16'h58, r);
        for (int w = 0; w < 256; w++) begin
            rd(0);
            chk("pio", {sn, w[7:0]}, r);
        end
    endtask
    task automatic dma(int n, logic [7:0] sn);
        for (int k = 0; k < n; k++)
            for (int w = 0; w < 256; w++) begin
                for (int i = 0; i < 900 && dmarq !== 1'b1; i++)
                    @(negedge clock);
                dmack_n = 0; iord_n = 0;
                @(negedge clock); @(negedge clock);
                chk("dma", {sn + k[7:0], w[7:0]}, dma_data);
                iord_n = 1;
                @(negedge clock);
            end
        dmack_n = 1;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #300_000 error_cnt++;
        final_report();
    end
    initial begin
        repeat (3) @(negedge clock); reset = 0;
        wr(7, 8'h00); chk("intrq", 1, intrq);
        rd(1); chk("error", 16'h04, r);
        rd(7); chk("status", 16'h51, r);
        for (int i = 0; i < 2; i++) begin
            wr(7, i ? 8'he1 : 8'h95); @(negedge clock);
            chk("idle", 1, idle_mode); chk("intrq", 1, intrq);
        end
        wr(2, 8'h10); wr(6, 8'h03);
        wr(7, 8'h91); chk("intrq", 1, intrq);
        s = 8'(xs()) & 8'h7f; ints = 0; wr(2, 8'h02); wr(3, s);
        wr(4, 8'(xs())); wr(5, 8'(xs())); wr(6, 8'he0); wr(7, 8'hc8);
        dma(2, s); wint(); chk("intrq", 1, intrq);
        chk("ints", 1, ints[15:0]);
        wr(7, 8'he4); pio(s + 8'h01);
        byte_mode_en = 1; wr(7, 8'hc8); byte_mode_en = 0;
        rd(1); chk("error", 16'h04, r);
        wr(7, 8'hc4); rd(1); chk("error", 16'h04, r);
        multi_block_size = 9'h002; ints = 0;
        wr(2, 8'h03); wr(3, 8'h10); wr(6, 8'h03); wr(7, 8'hc4);
        pio(8'h10); pio(8'h01); pio(8'h02);
        repeat (20) @(negedge clock);
        chk("ints", 2, ints[15:0]);
        rd(6); chk("head", 16'h00, r);
        unc_on = 1; wr(2, 8'h02); wr(3, s); wr(7, 8'hc8); wint();
        rd(1); chk("error", 16'h40, r);
        rd(3); chk("sector", {8'h00, s}, r); chk("dmarq", 0, dmarq);
        final_report();
    end
endmodule // ata_read_and_idle_command_engine_tb_top
`default_nettype wire
